// ===== verilog/crac_params.svh
// offsets, field positions, reset values and sizes of the cell register control block
// assumes inclusion by the package and the top module only
`ifndef CRAC_PARAMS_SVH
`define CRAC_PARAMS_SVH

// ==========================================
// register offsets (byte addresses)
`define CRAC_CTRL_OFF 12'h000
`define CRAC_STAT_OFF 12'h004

// ==========================================
// control register fields
`define CRAC_MODE_LSB 0
`define CRAC_MODE_MSB 2
`define CRAC_CLRSEL_BIT 3
`define CRAC_CESEL_LSB 4
`define CRAC_CESEL_MSB 6
`define CRAC_CE_ALWAYS 3'h7
`define CRAC_CTRL_RST 32'h0000_0070

// ==========================================
// status register fields
`define CRAC_STAT_Q_BIT 0
`define CRAC_STAT_FORCE_BIT 1
`define CRAC_STAT_DED_LSB 8
`define CRAC_STAT_DED_MSB 13

// ==========================================
// sizes
`define CRAC_NUM_DED 6

`endif

// ===== verilog/crac_pkg.sv
// types of the cell register control block
// assumes crac_params.svh is on the include path
`include "crac_params.svh"

package crac_pkg;

    // ==========================================
    // control modes
    typedef enum logic [2:0] {
        CRAC_MODE_CLR = 3'h0,
        CRAC_MODE_PRE = 3'h1,
        CRAC_MODE_CLR_PRE = 3'h2,
        CRAC_MODE_LOAD_CLR = 3'h3,
        CRAC_MODE_LOAD_PRE = 3'h4,
        CRAC_MODE_LOAD = 3'h5
    } crac_mode_t;

    // ==========================================
    // configuration held in the control register
    typedef struct packed {
        logic [2:0] ce_sel;
        logic clr_sel;
        logic [2:0] mode;
    } crac_cfg_t;

    // ==========================================
    // cell inputs that steer the asynchronous controls, active high
    typedef struct packed {
        logic group_control_line_one;
        logic group_control_line_two;
        logic cell_input_three;
    } crac_lines_t;

    // ==========================================
    // resolved asynchronous controls, active low
    typedef struct packed {
        logic clr_n;
        logic pre_n;
    } crac_async_t;

endpackage : crac_pkg

// ===== verilog/crac_top.sv
// cell register with asynchronous clear, preset and load control, apb configured
// assumes an apb master on pclk; group lines come from logic on pclk; dedicated pins are async
`timescale 1ns/1ps
`include "crac_params.svh"

// ==========================================

module crac_top (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // logic cell
    input wire crac_pkg::crac_lines_t group_lines,
    input wire logic cell_d,
    output logic cell_q,
    // dedicated inputs
    input wire logic [`CRAC_NUM_DED-1:0] ded_pin,
    output logic [`CRAC_NUM_DED-1:0] global_ctrl,
    output logic [`CRAC_NUM_DED-1:0] ded_data
);
    import crac_pkg::*;

    // ==========================================
    // mode decode into active low clear and preset
    function automatic crac_async_t decode_async(
        input logic [2:0] mode,
        input logic clr_sel,
        input crac_lines_t lines
    );
        crac_async_t r;
        logic sel_line;
        logic other_line;
        logic load_hi;
        logic load_lo;
        r.clr_n = 1'b1;
        r.pre_n = 1'b1;
        sel_line = clr_sel ? lines.group_control_line_two : lines.group_control_line_one;
        other_line = clr_sel ? lines.group_control_line_one : lines.group_control_line_two;
        // load realised through clear/preset, as the cell does
        load_hi = lines.group_control_line_one & lines.cell_input_three;
        load_lo = lines.group_control_line_one & ~lines.cell_input_three;
        case (mode)
            CRAC_MODE_CLR: begin
                r.clr_n = ~sel_line;
            end
            CRAC_MODE_PRE: begin
                r.pre_n = ~sel_line;
            end
            CRAC_MODE_CLR_PRE: begin
                r.clr_n = ~sel_line;
                r.pre_n = ~other_line;
            end
            CRAC_MODE_LOAD_CLR: begin
                r.clr_n = ~(lines.group_control_line_two | load_lo);
                r.pre_n = ~load_hi;
            end
            CRAC_MODE_LOAD_PRE: begin
                r.clr_n = ~load_lo;
                r.pre_n = ~(lines.group_control_line_two | load_hi);
            end
            CRAC_MODE_LOAD: begin
                r.clr_n = ~load_lo;
                r.pre_n = ~load_hi;
            end
            default: begin
                r.clr_n = 1'b1;
                r.pre_n = 1'b1;
            end
        endcase
        return r;
    endfunction : decode_async

    // ==========================================
    // control word to configuration
    function automatic crac_cfg_t unpack_ctrl(
        input logic [31:0] word
    );
        crac_cfg_t c;
        c.mode = word[`CRAC_MODE_MSB:`CRAC_MODE_LSB];
        c.clr_sel = word[`CRAC_CLRSEL_BIT];
        c.ce_sel = word[`CRAC_CESEL_MSB:`CRAC_CESEL_LSB];
        return c;
    endfunction : unpack_ctrl

    // ==========================================
    // configuration to control word, unused bits read zero
    function automatic logic [31:0] pack_ctrl(
        input crac_cfg_t c
    );
        logic [31:0] word;
        word = 32'h0;
        word[`CRAC_MODE_MSB:`CRAC_MODE_LSB] = c.mode;
        word[`CRAC_CLRSEL_BIT] = c.clr_sel;
        word[`CRAC_CESEL_MSB:`CRAC_CESEL_LSB] = c.ce_sel;
        return word;
    endfunction : pack_ctrl

    // ==========================================
    // status word
    function automatic logic [31:0] pack_status(
        input logic q,
        input logic frc,
        input logic [`CRAC_NUM_DED-1:0] ded
    );
        logic [31:0] word;
        word = 32'h0;
        word[`CRAC_STAT_Q_BIT] = q;
        word[`CRAC_STAT_FORCE_BIT] = frc;
        word[`CRAC_STAT_DED_MSB:`CRAC_STAT_DED_LSB] = ded;
        return word;
    endfunction : pack_status

    // ==========================================
    // clock enable pick
    // selects past the last dedicated input run free, never an unknown
    function automatic logic ce_gate(
        input logic [2:0] sel,
        input logic [`CRAC_NUM_DED-1:0] ded
    );
        logic en;
        en = 1'b1;
        if (sel < 3'(`CRAC_NUM_DED)) begin
            en = ded[sel];
        end
        return en;
    endfunction : ce_gate

    // ==========================================
    // state
    crac_cfg_t cfg;
    logic stored_q;
    logic [`CRAC_NUM_DED-1:0] ded_meta;
    logic [`CRAC_NUM_DED-1:0] ded_sync;
    logic [`CRAC_NUM_DED-1:0] ded_dist;

    // ==========================================
    // apb decode
    wire logic setup_phase = psel & ~penable;
    wire logic access_phase = psel & penable;
    wire logic hit_ctrl = (paddr == `CRAC_CTRL_OFF);
    wire logic hit_stat = (paddr == `CRAC_STAT_OFF);
    wire logic mapped = hit_ctrl | hit_stat;
    wire logic ctrl_wr = access_phase & pwrite & hit_ctrl;
    wire crac_cfg_t next_cfg = unpack_ctrl(pwdata);

    // ==========================================
    // asynchronous controls and cell output
    wire crac_async_t ctl = decode_async(cfg.mode, cfg.clr_sel, group_lines);
    wire logic forcing = ~ctl.clr_n | ~ctl.pre_n;
    // clear wins over preset and load
    wire logic forced_val = ctl.clr_n;
    wire logic ce_on = ce_gate(cfg.ce_sel, ded_dist);
    wire logic next_stored_q = forcing ? forced_val : (ce_on ? cell_d : stored_q);

    // output follows the force at once, no clock needed
    assign cell_q = forcing ? forced_val : stored_q;

    wire logic [31:0] stat_word = pack_status(cell_q, forcing, ded_sync);
    wire logic [31:0] ctrl_word = pack_ctrl(cfg);
    wire logic [31:0] next_prdata = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);

    assign pready = 1'b1;
    assign pslverr = access_phase & ~mapped;
    assign global_ctrl = ded_dist;
    assign ded_data = ded_dist;

    // ==========================================
    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= crac_cfg_t'(7'(`CRAC_CTRL_RST));
        end else if (ctrl_wr) begin
            cfg <= next_cfg;
        end
    end

    // ==========================================
    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup_phase & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ==========================================
    // cell storage register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stored_q <= 1'b0;
        end else begin
            stored_q <= next_stored_q;
        end
    end

    // ==========================================
    // dedicated inputs: synchronise then distribute
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ded_meta <= 6'h0;
            ded_sync <= 6'h0;
            ded_dist <= 6'h0;
        end else begin
            ded_meta <= ded_pin;
            ded_sync <= ded_meta;
            ded_dist <= ded_sync;
        end
    end

endmodule : crac_top

// ===== testbench/crac_top_properties.sv
// port checker for the cell register control block
// assumes binding into crac_top; cfg shadows apb writes
`timescale 1ns/1ps
module crac_checker (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // cell and dedicated
    input wire crac_pkg::crac_lines_t group_lines,
    input wire logic cell_q,
    input wire logic [5:0] ded_pin,
    input wire logic [5:0] global_ctrl,
    input wire logic [5:0] ded_data
);
    logic [3:0] cfg;
    wire acc = psel && penable;
    wire bad = acc && paddr != 12'h000 && paddr != 12'h004;
    wire l1 = group_lines.group_control_line_one;
    wire l2 = group_lines.group_control_line_two;
    wire d3 = group_lines.cell_input_three;
    wire s = cfg[3] ? l2 : l1;
    wire [2:0] m = cfg[2:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 4'h0;
        end else if (acc && pwrite && paddr == 12'h000) begin
            cfg <= pwdata[3:0];
        end
    end
    chk_bad_addr: assert property (bad |-> pslverr) else $error("addr");
    chk_ded_delay:
        assert property (global_ctrl == $past(ded_pin, 3)) else $error("ded");
    chk_ded_data: assert property (ded_data == global_ctrl) else $error("data");
    chk_clr_sel:
        assert property ((m == 3'h0 || m == 3'h2) && s |-> !cell_q) else $error("clr");
    chk_pre_sel: assert property (m == 3'h1 && s |-> cell_q) else $error("pre");
    chk_load_data:
        assert property (m > 3'h2 && m < 3'h6 && l1 && !l2 |-> cell_q == d3) else $error("load");
    chk_load_clr: assert property (m == 3'h3 && l2 |-> !cell_q) else $error("lclr");
    chk_load_pre: assert property (m == 3'h4 && l2 && !l1 |-> cell_q) else $error("lpre");
    cover property (bad);
    cover property (m == 3'h2 && l1 && l2);
    cover property (m == 3'h5 && l1);
    cover property (m == 3'h3 && l1 && l2);
endmodule : crac_checker
bind crac_top crac_checker u_crac_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pslverr, .group_lines, .cell_q, .ded_pin, .global_ctrl, .ded_data);

// ===== testbench/crac_top_tb_top.sv
// self-checking bench for the cell register control block
// assumes the design files are compiled first
`timescale 1ns/1ps
module crac_top_tb_top;
    import crac_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic cell_d = 1'b0, pready, pslverr, cell_q, er, l1, l2, d3;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] ded_pin = 6'h0, global_ctrl, ded_data, hist[$];
    crac_lines_t group_lines = '0;
    int num_errors = 0, total_checks = 0, st, fv, m, cs, ce;
    always #2 pclk = ~pclk;
    crac_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .group_lines, .cell_d, .cell_q, .ded_pin, .global_ctrl, .ded_data);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_cell(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask : chk_cell
    task automatic chk_ded(input logic [5:0] got, input logic [5:0] exp);
        chk(32'(got), 32'(exp));
    endtask : chk_ded
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (int n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // 2 when the cell is not forced, else the forced level
    function automatic int force_of(int m, int cs, int a, int b, int d);
        int s = cs ? b : a;
        case (m)
            0: return s ? 0 : 2;
            1: return s ? 1 : 2;
            2: return s ? 0 : ((cs ? a : b) ? 1 : 2);
            3: return b ? 0 : (a ? d : 2);
            4: return a ? d : (b ? 1 : 2);
            5: return a ? d : 2;
            default: return 2;
        endcase
    endfunction : force_of
    initial begin
        void'($urandom(32'h03a9d788));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        chk(32'(er), 32'h1);
        for (int k = 0; k < 20; k++) begin
            m = (k < 18) ? (k / 2) % 6 : k - 12;
            cs = k % 2;
            ce = (k < 12 || k > 17) ? 7 : k - 12;
            apb(1'b1, 12'h000, m | cs << 3 | ce << 4);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, m | cs << 3 | ce << 4);
            chk(32'(er), 32'h0);
            fv = 2;
            st = cell_d;
            hist = '{ded_pin, ded_pin, ded_pin, ded_pin};
            repeat (40) begin
                @(posedge pclk);
                st = (fv != 2) ? fv : ((ce == 7 || hist[$ - 3][ce]) ? cell_d : st);
                l1 = 1'($urandom);
                l2 = 1'($urandom) && !(m == 4 && l1);
                d3 = 1'($urandom);
                group_lines <= {l1, l2, d3};
                cell_d <= 1'($urandom);
                ded_pin <= 6'($urandom);
                #1;
                fv = force_of(m, cs, l1, l2, d3);
                hist.push_back(ded_pin);
                chk_cell(cell_q, 1'((fv == 2) ? st : fv));
                chk_ded(global_ctrl, hist[$ - 3]);
                chk_ded(ded_data, hist[$ - 3]);
            end
            @(posedge pclk);
            group_lines <= '0;
            ded_pin[ce % 6] <= 1'b1;
            repeat (4) @(posedge pclk);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, {18'h0, ded_pin, 7'h0, cell_d});
        end
        give_verdict();
    end
endmodule : crac_top_tb_top
